// ### ups_packet_status_phy_ctrl.v
// Purpose: Packet status capture and transceiver control registers
// Assumes: APB slave with no wait states, all inputs synchronous to clk
// Notes:   Every output is registered
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ups_regs.vh"

// Function
// - The last received packet identifier is kept in a read-only field.
// - The last received endpoint number is kept read-only.
// - Bit 4 of the endpoint register flags a valid endpoint number.
// - A 16-bit writable mask holds one tag bit per endpoint.
// - A tagged endpoint leaves on the receive port ORed with 0x10.
// - Control bit 18 set disables the byte port pulldowns.
// - An auto-resume from reset signalling sets bit 13 until zeroed.
// - An auto-resume from K signalling sets bit 12 until zeroed.
// - Line state changes wait two to the power of bits 11:8 clocks.
// - Bit 7 selects hardware wake, else software polls line state.
// - Bits 6:4 drive the three transceiver configuration pins.
module ups_packet_status_phy_ctrl (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Received packet
    input  wire        pktValid,
    input  wire [3:0]  pktIdent,
    input  wire [3:0]  pktEndpoint,
    input  wire        pktEndpointValid,
    // Receive port
    output reg  [4:0]  rxEndpoint_q,
    output reg         rxEndpointValid_q,
    // Line state and suspend
    input  wire [1:0]  lineState,
    input  wire        suspended,
    output reg  [1:0]  lineStateFilt_q,
    output reg         resumeReq_q,
    // Transceiver and ports
    output reg  [2:0]  transceiverConfigPins_q,
    output reg         bytePortPulldownEn_q,
    // Interrupt
    output reg         irq_q
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg  [3:0]                pid_q;
    reg  [3:0]                endpoint_q;
    reg                       endpointValid_q;
    reg  [15:0]               tagMask_q;
    reg  [31:0]               otgMask_q;
    reg  [`UPS_PWR_SIG_WIDTH-1:0] powerSig_q;
    reg                       pulldownOff_q;
    reg                       resumeSe0_q;
    reg                       resumeK_q;
    reg  [3:0]                filtLog2_q;
    reg                       autoResume_q;
    reg  [2:0]                confPins_q;
    reg  [`UPS_EVT_COUNT-1:0] evtStatus_q;
    reg  [`UPS_EVT_COUNT-1:0] evtMask_q;

    wire [1:0]                lineFilt;
    wire                      wakeSe0;
    wire                      wakeK;
    wire [`UPS_EVT_COUNT-1:0] evtSet;
    wire                      access;
    wire                      wrEn;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    ups_line_filter u_filter (
        .clk        (clk),
        .rst        (rst),
        .delayLog2  (filtLog2_q),
        .lineRaw    (lineState),
        .lineFilt_q (lineFilt)
    );

    ups_resume_detect u_resume (
        .clk        (clk),
        .rst        (rst),
        .autoEnable (autoResume_q),
        .suspended  (suspended),
        .lineFilt   (lineFilt),
        .wakeSe0_q  (wakeSe0),
        .wakeK_q    (wakeK)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function mapped;
        input [7:0] addr;
        begin
            case (addr)
                `UPS_OFF_LAST_PACKET_IDENT,
                `UPS_OFF_LAST_ENDPOINT,
                `UPS_OFF_ENDPOINT_TAG_MASK,
                `UPS_OFF_OTG_FLAG_MASK,
                `UPS_OFF_POWER_SIGNALLING,
                `UPS_OFF_TRANSCEIVER_CONTROL,
                `UPS_OFF_EVENT_STATUS,
                `UPS_OFF_EVENT_MASK: mapped = 1'b1;
                default:             mapped = 1'b0;
            endcase
        end
    endfunction

    function sel;
        input [7:0] addr;
        input [7:0] offset;
        begin
            sel = (addr == offset);
        end
    endfunction

    // Access edge is the one where pready is seen high
    assign access = psel & penable & pready;
    assign wrEn   = access & pwrite & mapped(paddr);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    reg [31:0] rdMux;

    always @* begin
        rdMux = `UPS_RESET_WORD;
        case (paddr)
            `UPS_OFF_LAST_PACKET_IDENT: begin
                rdMux[3:0] = pid_q;
            end
            `UPS_OFF_LAST_ENDPOINT: begin
                rdMux[3:0]              = endpoint_q;
                rdMux[`UPS_EP_VALID_BIT] = endpointValid_q;
            end
            `UPS_OFF_ENDPOINT_TAG_MASK: begin
                rdMux[15:0] = tagMask_q;
            end
            `UPS_OFF_OTG_FLAG_MASK: begin
                rdMux = otgMask_q;
            end
            `UPS_OFF_POWER_SIGNALLING: begin
                rdMux[`UPS_PWR_SIG_WIDTH-1:0] = powerSig_q;
            end
            `UPS_OFF_TRANSCEIVER_CONTROL: begin
                rdMux[`UPS_CTL_PULLDOWN_OFF] = pulldownOff_q;
                rdMux[`UPS_CTL_RESUME_SE0]   = resumeSe0_q;
                rdMux[`UPS_CTL_RESUME_K]     = resumeK_q;
                rdMux[`UPS_CTL_FILT_HI:`UPS_CTL_FILT_LO] = filtLog2_q;
                rdMux[`UPS_CTL_AUTO_RESUME]  = autoResume_q;
                rdMux[`UPS_CTL_CONF_HI:`UPS_CTL_CONF_LO] = confPins_q;
            end
            `UPS_OFF_EVENT_STATUS: begin
                rdMux[`UPS_EVT_COUNT-1:0] = evtStatus_q;
            end
            `UPS_OFF_EVENT_MASK: begin
                rdMux[`UPS_EVT_COUNT-1:0] = evtMask_q;
            end
            default: begin
                rdMux = `UPS_RESET_WORD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // Flops loaded in the setup phase drive prdata and pready with no wait state
    always @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `UPS_RESET_WORD;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= ~mapped(paddr);
            prdata  <= pwrite ? `UPS_RESET_WORD : rdMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `UPS_RESET_WORD;
        end
    end

    // ------------------------------------------------------------------
    // Packet capture
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            pid_q             <= 4'h0;
            endpoint_q        <= 4'h0;
            endpointValid_q   <= 1'b0;
            rxEndpoint_q      <= 5'h0_0;
            rxEndpointValid_q <= 1'b0;
        end else begin
            rxEndpointValid_q <= 1'b0;
            if (pktValid) begin
                pid_q           <= pktIdent;
                endpointValid_q <= pktEndpointValid;
                if (pktEndpointValid) begin
                    endpoint_q        <= pktEndpoint;
                    rxEndpointValid_q <= 1'b1;
                    rxEndpoint_q      <= {1'b0, pktEndpoint} |
                        (tagMask_q[pktEndpoint] ? `UPS_EP_TAG_VALUE
                                                : 5'h0_0);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            tagMask_q     <= 16'h0000;
            otgMask_q     <= `UPS_RESET_WORD;
            powerSig_q    <= {`UPS_PWR_SIG_WIDTH{1'b0}};
            pulldownOff_q <= 1'b0;
            filtLog2_q    <= 4'h0;
            autoResume_q  <= 1'b0;
            confPins_q    <= 3'h0;
            evtMask_q     <= {`UPS_EVT_COUNT{1'b0}};
        end else if (wrEn) begin
            if (sel(paddr, `UPS_OFF_ENDPOINT_TAG_MASK)) begin
                tagMask_q <= pwdata[15:0];
            end
            if (sel(paddr, `UPS_OFF_OTG_FLAG_MASK)) begin
                otgMask_q <= pwdata;
            end
            if (sel(paddr, `UPS_OFF_POWER_SIGNALLING)) begin
                powerSig_q <= pwdata[`UPS_PWR_SIG_WIDTH-1:0];
            end
            if (sel(paddr, `UPS_OFF_TRANSCEIVER_CONTROL)) begin
                pulldownOff_q <= pwdata[`UPS_CTL_PULLDOWN_OFF];
                filtLog2_q    <= pwdata[`UPS_CTL_FILT_HI:`UPS_CTL_FILT_LO];
                autoResume_q  <= pwdata[`UPS_CTL_AUTO_RESUME];
                confPins_q    <= pwdata[`UPS_CTL_CONF_HI:`UPS_CTL_CONF_LO];
            end
            if (sel(paddr, `UPS_OFF_EVENT_MASK)) begin
                evtMask_q <= pwdata[`UPS_EVT_COUNT-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Resume cause flags
    // ------------------------------------------------------------------
    wire ctlWr = wrEn & sel(paddr, `UPS_OFF_TRANSCEIVER_CONTROL);

    // Wake wins over a clearing write in the same cycle
    always @(posedge clk) begin
        if (rst) begin
            resumeSe0_q <= 1'b0;
            resumeK_q   <= 1'b0;
        end else begin
            if (wakeSe0) begin
                resumeSe0_q <= 1'b1;
            end else if (ctlWr && !pwdata[`UPS_CTL_RESUME_SE0]) begin
                resumeSe0_q <= 1'b0;
            end
            if (wakeK) begin
                resumeK_q <= 1'b1;
            end else if (ctlWr && !pwdata[`UPS_CTL_RESUME_K]) begin
                resumeK_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------------
    assign evtSet[`UPS_EVT_PACKET]     = pktValid;
    assign evtSet[`UPS_EVT_RESUME_SE0] = wakeSe0;
    assign evtSet[`UPS_EVT_RESUME_K]   = wakeK;

    wire stsWr = wrEn & sel(paddr, `UPS_OFF_EVENT_STATUS);

    genvar gi;
    generate
        for (gi = 0; gi < `UPS_EVT_COUNT; gi = gi + 1) begin : g_evt
            always @(posedge clk) begin
                if (rst) begin
                    evtStatus_q[gi] <= 1'b0;
                end else if (evtSet[gi]) begin
                    evtStatus_q[gi] <= 1'b1;
                end else if (stsWr && pwdata[gi]) begin
                    evtStatus_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            irq_q                   <= 1'b0;
            lineStateFilt_q         <= `UPS_LINE_SE0;
            resumeReq_q             <= 1'b0;
            transceiverConfigPins_q <= 3'h0;
            bytePortPulldownEn_q    <= 1'b1;
        end else begin
            irq_q                   <= |(evtStatus_q & evtMask_q);
            lineStateFilt_q         <= lineFilt;
            resumeReq_q             <= wakeSe0 | wakeK;
            transceiverConfigPins_q <= confPins_q;
            bytePortPulldownEn_q    <= ~pulldownOff_q;
        end
    end

endmodule
`default_nettype wire

// ### ups_regs.vh
// Purpose: Register map and constants of the USB packet status block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef UPS_REGS_VH
`define UPS_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UPS_OFF_LAST_PACKET_IDENT   8'h2c
`define UPS_OFF_LAST_ENDPOINT       8'h30
`define UPS_OFF_ENDPOINT_TAG_MASK   8'h34
`define UPS_OFF_OTG_FLAG_MASK       8'h38
`define UPS_OFF_POWER_SIGNALLING    8'h3c
`define UPS_OFF_TRANSCEIVER_CONTROL 8'h40
`define UPS_OFF_EVENT_STATUS        8'h44
`define UPS_OFF_EVENT_MASK          8'h48

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UPS_EP_VALID_BIT        4
`define UPS_EP_TAG_VALUE        5'h10
`define UPS_PWR_SIG_WIDTH       9
`define UPS_CTL_PULLDOWN_OFF    18
`define UPS_CTL_RESUME_SE0      13
`define UPS_CTL_RESUME_K        12
`define UPS_CTL_FILT_HI         11
`define UPS_CTL_FILT_LO         8
`define UPS_CTL_AUTO_RESUME     7
`define UPS_CTL_CONF_HI         6
`define UPS_CTL_CONF_LO         4
`define UPS_CTL_WRITE_MASK      32'h0004_0ff0

// ----------------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------------
`define UPS_EVT_COUNT           3
`define UPS_EVT_PACKET          0
`define UPS_EVT_RESUME_SE0      1
`define UPS_EVT_RESUME_K        2

// ----------------------------------------------------------------------
// Reset values and line states
// ----------------------------------------------------------------------
`define UPS_RESET_WORD          32'h0000_0000
`define UPS_LINE_SE0            2'h0
`define UPS_LINE_J              2'h1
`define UPS_LINE_K              2'h2
`define UPS_FILT_CNT_WIDTH      16

`endif

// ### ups_line_filter.v
// Purpose: Hold-off filter on the bus line state
// Assumes: Raw line state synchronous to clk
// Notes:   New state must stay stable 2**shift clocks to pass
`timescale 1ns/100ps
`default_nettype none
`include "ups_regs.vh"

module ups_line_filter (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire [3:0] delayLog2,
    // Line state
    input  wire [1:0] lineRaw,
    output reg  [1:0] lineFilt_q
);

    reg  [1:0]                     cand_q;
    reg  [`UPS_FILT_CNT_WIDTH-1:0] cnt_q;
    wire [`UPS_FILT_CNT_WIDTH-1:0] limit;

    // Terminal count is one less than the delay
    assign limit = ({{(`UPS_FILT_CNT_WIDTH-1){1'b0}}, 1'b1} << delayLog2)
                   - {{(`UPS_FILT_CNT_WIDTH-1){1'b0}}, 1'b1};

    always @(posedge clk) begin
        if (rst) begin
            cand_q     <= `UPS_LINE_SE0;
            cnt_q      <= {`UPS_FILT_CNT_WIDTH{1'b0}};
            lineFilt_q <= `UPS_LINE_SE0;
        end else if (lineRaw != cand_q) begin
            // A glitch restarts the wait
            cand_q <= lineRaw;
            cnt_q  <= {`UPS_FILT_CNT_WIDTH{1'b0}};
        end else if (cand_q != lineFilt_q) begin
            if (cnt_q >= limit) begin
                lineFilt_q <= cand_q;
                cnt_q      <= {`UPS_FILT_CNT_WIDTH{1'b0}};
            end else begin
                cnt_q <= cnt_q + {{(`UPS_FILT_CNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule
`default_nettype wire

// ### ups_resume_detect.v
// Purpose: Suspend controller wake detection
// Assumes: Filtered line state, suspend level from link logic
// Notes:   One wake per arming; re-arms on J while still suspended
`timescale 1ns/100ps
`default_nettype none
`include "ups_regs.vh"

module ups_resume_detect (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire       autoEnable,
    input  wire       suspended,
    input  wire [1:0] lineFilt,
    // Wake pulses
    output reg        wakeSe0_q,
    output reg        wakeK_q
);

    localparam ST_IDLE  = 2'b01;
    localparam ST_ARMED = 2'b10;

    reg [1:0] state_q;

    always @(posedge clk) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            wakeSe0_q <= 1'b0;
            wakeK_q   <= 1'b0;
        end else begin
            wakeSe0_q <= 1'b0;
            wakeK_q   <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (suspended && autoEnable && lineFilt == `UPS_LINE_J) begin
                        state_q <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    // Polled mode leaves wake to software
                    if (!suspended || !autoEnable) begin
                        state_q <= ST_IDLE;
                    end else if (lineFilt == `UPS_LINE_SE0) begin
                        wakeSe0_q <= 1'b1;
                        state_q   <= ST_IDLE;
                    end else if (lineFilt == `UPS_LINE_K) begin
                        wakeK_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### ups_checker_sva.sv
// Purpose: Port-level assertions for the packet status block
// Assumes: Zero-wait APB slave, sync active-high reset
// Notes:   Bound into the design top
`timescale 1ns/100ps
`default_nettype none
`include "ups_regs.vh"
module ups_checker (
    // Clock, reset and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Packet, line and outputs
    input wire logic        pktValid,
    input wire logic [3:0]  pktEndpoint,
    input wire logic        pktEndpointValid,
    input wire logic [4:0]  rxEndpoint_q,
    input wire logic        rxEndpointValid_q,
    input wire logic        suspended,
    input wire logic        resumeReq_q,
    input wire logic [2:0]  transceiverConfigPins_q,
    input wire logic        bytePortPulldownEn_q
);
    wire ctlWr = psel && penable && pready && pwrite
                 && paddr == `UPS_OFF_TRANSCEIVER_CONTROL;
    wire pktEp = pktValid && pktEndpointValid;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_after_setup: assert property (
        psel && !penable |=> pready) else $error("no pready");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("long pready");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("lone pslverr");
    a_ident_reserved: assert property (pready && !pwrite
        && paddr == `UPS_OFF_LAST_PACKET_IDENT |-> prdata[31:4] == 28'h0)
        else $error("ident reserved");
    a_rx_valid_follow: assert property (pktEp |=> rxEndpointValid_q)
        else $error("no rx valid");
    a_rx_valid_cause: assert property (
        rxEndpointValid_q |-> $past(pktEp)) else $error("stray rx valid");
    a_rx_ep_number: assert property (pktEp |=>
        rxEndpoint_q[3:0] == $past(pktEndpoint))
        else $error("rx endpoint");
    a_config_pins: assert property (ctlWr |=> ##1
        transceiverConfigPins_q == $past(pwdata[6:4], 2))
        else $error("config pins");
    a_pulldown_ctl: assert property (ctlWr |=> ##1
        bytePortPulldownEn_q == !$past(pwdata[18], 2))
        else $error("pulldown");
    a_wake_pulse: assert property (resumeReq_q |=> !resumeReq_q)
        else $error("long wake");
    a_wake_suspended: assert property (
        resumeReq_q |-> $past(suspended, 2)) else $error("wake unsuspended");
    c_ctl_write: cover property (ctlWr);
    c_tagged_rx: cover property (rxEndpointValid_q && rxEndpoint_q[4]);
    c_wake: cover property (resumeReq_q);
endmodule
bind ups_packet_status_phy_ctrl ups_checker u_chk (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pktValid, .pktEndpoint, .pktEndpointValid, .rxEndpoint_q,
    .rxEndpointValid_q, .suspended, .resumeReq_q,
    .transceiverConfigPins_q, .bytePortPulldownEn_q);
`default_nettype wire

// ### ups_host_model.sv
// Purpose: Transceiver and upstream host stand-in
// Assumes: Packets and line state synchronous to clk
// Notes:   Qualifiers go to inverse values outside a packet
`timescale 1ns/100ps
`default_nettype none
`include "ups_regs.vh"
module ups_host_model (
    input  wire logic       clk,
    output logic            pktValid,
    output logic [3:0]      pktIdent,
    output logic [3:0]      pktEndpoint,
    output logic            pktEndpointValid,
    output logic [1:0]      lineState,
    output logic            suspended
);
    initial begin
        {pktValid, pktIdent, pktEndpoint} = 9'h000;
        {pktEndpointValid, suspended} = 2'h0;
        lineState = `UPS_LINE_J;
    end
    task automatic sendPacket(input logic [3:0] id, ep, input logic epv);
        @(posedge clk);
        pktValid <= 1'b1;
        pktIdent <= id;
        pktEndpoint <= ep;
        pktEndpointValid <= epv;
        @(posedge clk);
        pktValid <= 1'b0;
        pktIdent <= ~id;
        pktEndpoint <= ~ep;
        pktEndpointValid <= ~epv;
    endtask
    // Idle J; SE0 or K wakes
    task automatic setLine(input logic [1:0] s);
        @(posedge clk);
        lineState <= s;
    endtask
    task automatic setSusp(input logic s);
        @(posedge clk);
        suspended <= s;
    endtask
endmodule
`default_nettype wire

// ### ups_packet_status_phy_ctrl_bench.sv
// Purpose: Self-checking bench for the packet status block
// Assumes: 10 MHz clock, APB master with one-cycle setup
// Notes:   Host model is the far side
`timescale 1ns/100ps
`default_nettype none
`include "ups_regs.vh"
module ups_packet_status_phy_ctrl_bench;
    localparam CTL = `UPS_OFF_TRANSCEIVER_CONTROL;
    localparam STAT = `UPS_OFF_EVENT_STATUS;
    localparam EMSK = `UPS_OFF_EVENT_MASK;
    localparam EPR = `UPS_OFF_LAST_ENDPOINT;
    localparam PID = `UPS_OFF_LAST_PACKET_IDENT;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, pktValid, pktEndpointValid;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic [3:0] pktIdent, pktEndpoint;
    logic [4:0] rxEndpoint_q;
    logic [2:0] pins;
    logic [1:0] lineState, lineFilt;
    logic rxValid, suspended, resumeReq, pullEn, irq, errv;
    int fail_count = 0, n_compared = 0;
    always #50 clk = ~clk;
    ups_host_model u_host (.clk, .pktValid, .pktIdent, .pktEndpoint,
        .pktEndpointValid, .lineState, .suspended);
    ups_packet_status_phy_ctrl u_dut (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pktValid, .pktIdent,
        .pktEndpoint, .pktEndpointValid, .rxEndpoint_q,
        .rxEndpointValid_q(rxValid), .lineState, .suspended,
        .lineStateFilt_q(lineFilt), .resumeReq_q(resumeReq),
        .transceiverConfigPins_q(pins), .bytePortPulldownEn_q(pullEn),
        .irq_q(irq));
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        check("pready wait", n, 1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check($sformatf("read %h", a), rdv, exp);
    endtask
    task automatic testReset;
        check("pulldown", 32'(pullEn), 1);
        check("pins", 32'(pins), 0);
        for (int i = 0; i < 8; i++) rdChk(PID + 8'(4*i), 0);
    endtask
    task automatic testAccess;
        apb(1'b0, 8'h4c, 32'h0000_0000);
        check("slverr", 32'(errv), 1);
        check("unmapped", rdv, 0);
        for (int i = 0; i < 5; i++) wr(PID + 8'(4*i), 32'hffff_ffff);
        rdChk(PID, 0);
        rdChk(EPR, 0);
        rdChk(`UPS_OFF_ENDPOINT_TAG_MASK, 32'h0000_ffff);
        rdChk(`UPS_OFF_OTG_FLAG_MASK, 32'hffff_ffff);
        rdChk(`UPS_OFF_POWER_SIGNALLING, 32'h0000_01ff);
        wr(CTL, 32'hffff_ffff);
        rdChk(CTL, 32'h0004_0ff0);
        check("pins set", 32'(pins), 7);
        check("pulldown off", 32'(pullEn), 0);
        wr(CTL, 32'h0000_0050);
        repeat (2) @(posedge clk);
        check("pins 5", 32'(pins), 5);
        check("pulldown on", 32'(pullEn), 1);
    endtask
    task automatic pkt(input logic [3:0] id, ep, input logic v,
                       input logic [4:0] rx, input logic [31:0] epReg);
        u_host.sendPacket(id, ep, v);
        @(posedge clk);
        check("rx valid", 32'(rxValid), 32'(v));
        check("rx endpoint", 32'(rxEndpoint_q), 32'(rx));
        rdChk(PID, 32'(id));
        rdChk(EPR, epReg);
    endtask
    task automatic testPacket;
        wr(`UPS_OFF_ENDPOINT_TAG_MASK, 32'h0000_0020);
        wr(EMSK, 32'h0000_0001);
        wr(STAT, 32'h0000_0007);
        pkt(4'hd, 4'h5, 1'b1, 5'h15, 32'h0000_0015);
        check("irq set", 32'(irq), 1);
        pkt(4'h7, 4'h3, 1'b1, 5'h03, 32'h0000_0013);
        pkt(4'h2, 4'h9, 1'b0, 5'h03, 32'h0000_0003);
        wr(STAT, 32'h0000_0001);
        wr(EMSK, 32'h0000_0000);
        u_host.sendPacket(4'h1, 4'h1, 1'b1);
        rdChk(STAT, 32'h0000_0001);
        check("irq masked", 32'(irq), 0);
        wr(STAT, 32'h0000_0001);
        rdChk(STAT, 32'h0000_0000);
    endtask
    task automatic testFilter;
        int n;
        for (int k = 1; k < 4; k++) begin
            wr(CTL, 32'(k) << 8);
            repeat (20) @(posedge clk);
            u_host.setLine(`UPS_LINE_K);
            u_host.setLine(`UPS_LINE_J);
            n = 0;
            repeat (20) @(posedge clk) n += int'(lineFilt === `UPS_LINE_K);
            check("glitch", 32'(n), 0);
            u_host.setLine(`UPS_LINE_K);
            n = 0;
            while (lineFilt !== `UPS_LINE_K && n < 40) @(posedge clk) n++;
            check("delay", 32'(n >= 2 ** k && n <= 2 ** k + 3), 1);
            u_host.setLine(`UPS_LINE_J);
        end
    endtask
    task automatic wakeCase(input logic en, input logic [1:0] s,
                            input logic [31:0] expCtl, expStat);
        logic seen;
        wr(CTL, {24'h0, en, 7'h0});
        wr(STAT, 32'h0000_0007);
        repeat (10) @(posedge clk);
        u_host.setSusp(1'b1);
        repeat (10) @(posedge clk);
        u_host.setLine(s);
        seen = 1'b0;
        repeat (30) @(posedge clk) seen |= (resumeReq === 1'b1);
        check("wake", 32'(seen), 32'(en));
        rdChk(CTL, expCtl);
        rdChk(STAT, expStat);
        u_host.setSusp(1'b0);
        u_host.setLine(`UPS_LINE_J);
        wr(CTL, 32'h0000_0000);
        rdChk(CTL, 32'h0000_0000);
    endtask
    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        testReset;
        testAccess;
        testPacket;
        testFilter;
        wakeCase(1'b0, `UPS_LINE_K, 32'h0000_0000, 32'h0000_0000);
        wakeCase(1'b1, `UPS_LINE_K, 32'h0000_1080, 32'h0000_0004);
        wakeCase(1'b1, `UPS_LINE_SE0, 32'h0000_2080, 32'h0000_0002);
        stop_test;
    end
endmodule
`default_nettype wire
